//--- common/ief_pkg.sv
// Package of offsets, field positions, masks and types for the interrupt bank
package ief_pkg;

    // Register byte offsets on the APB bus
    localparam logic [11:0] OFS_INTERRUPT_CONTROL      = 12'h000;
    localparam logic [11:0] OFS_PERIPHERAL_ENABLE_ONE  = 12'h004;
    localparam logic [11:0] OFS_PERIPHERAL_ENABLE_TWO  = 12'h008;
    localparam logic [11:0] OFS_PERIPHERAL_REQUEST_ONE = 12'h00c;
    localparam logic [11:0] OFS_EVENT_STATUS           = 12'h010;
    localparam logic [11:0] OFS_EVENT_MASK             = 12'h014;

    // Field positions in interrupt_control
    localparam int BIT_GLOBAL_IRQ_GATE      = 7;
    localparam int BIT_PERIPHERAL_GROUP     = 6;
    localparam int BIT_TIMER_ZERO_EN        = 5;
    localparam int BIT_EXT_PIN_EN           = 4;
    localparam int BIT_PIN_CHANGE_EN        = 3;
    localparam int BIT_TIMER_ZERO_PENDING   = 2;
    localparam int BIT_EXT_PIN_PENDING      = 1;
    localparam int BIT_PIN_CHANGE_SUMMARY   = 0;

    // Implemented-bit masks; unimplemented positions read as zero
    localparam logic [7:0] MASK_ENABLE_ONE  = 8'hfb;
    localparam logic [7:0] MASK_ENABLE_TWO  = 8'hee;
    localparam logic [7:0] MASK_REQUEST_ONE = 8'hfb;
    localparam logic [1:0] MASK_CORE_FLAGS  = 2'h3;

    // Reset value of every bank register
    localparam logic [7:0] RST_BANK = 8'h00;

    // Event status bit positions and width
    localparam int EVT_W          = 3;
    localparam int EVT_ACCEPTED   = 0;
    localparam int EVT_RETURNED   = 1;
    localparam int EVT_EXT_EDGE   = 2;
    localparam logic [2:0] RST_EVT = 3'h0;

    // APB phase tracker, one-hot
    typedef enum logic [1:0] {
        IEF_WAIT = 2'b01,
        IEF_ACK  = 2'b10
    } ief_phase_t;

    // Read answer carried as one unit
    typedef struct packed {
        logic [31:0] data;
        logic        err;
    } ief_rsp_t;

endpackage : ief_pkg

//--- rtl/ief_edge_detect.sv
// Selectable edge detector for the external interrupt pin
`timescale 1ns/1ps
module ief_edge_detect (
    input  wire logic mclk,         // System clock
    input  wire logic resetn,       // Asynchronous reset, active low
    input  wire logic pin,          // Pin level, synchronous to mclk
    input  wire logic rise_sel,     // One picks rising edges, zero falling
    output logic      edge_pulse    // One-cycle pulse on the chosen edge
);

    logic last_q;                   // Pin level one cycle ago

    // Remember the previous level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            last_q <= 1'b0;
        end else begin
            last_q <= pin;
        end
    end

    // Rising or falling edge as selected
    assign edge_pulse = rise_sel ? (pin & ~last_q) : (~pin & last_q);

endmodule : ief_edge_detect

//--- rtl/ief_flag_reg.sv
// Sticky pending-flag register: hardware sets, software writes, set wins
`timescale 1ns/1ps
module ief_flag_reg #(
    parameter int              W    = 8,        // Number of flags
    parameter logic [W-1:0]    IMPL = '1        // Implemented positions
) (
    input  wire logic         mclk,             // System clock
    input  wire logic         resetn,           // Asynchronous reset, active low
    input  wire logic [W-1:0] set,              // Source events, one-cycle
    input  wire logic         wr_en,            // Software write strobe
    input  wire logic [W-1:0] wr_data,          // Software write value
    output logic      [W-1:0] flag_q            // Current flags
);

    logic [W-1:0] flag_d;                       // Next flags

    // Write replaces, event ORs on top so it is never lost
    assign flag_d = IMPL & (set | (wr_en ? wr_data : flag_q));

    // Flags clear on reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule : ief_flag_reg

//--- rtl/ief_bank.sv
// Interrupt enable and pending-flag bank with APB register access
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module ief_bank #(
    parameter int PIN_CHANGE_W = 8              // Monitored pin-change lines
) (
    input  wire logic                    mclk,                // System clock, 20 MHz
    input  wire logic                    resetn,              // Async reset, active low
    input  wire logic                    psel,                // APB select
    input  wire logic                    penable,             // APB enable
    input  wire logic                    pwrite,              // APB direction
    input  wire logic [11:0]             paddr,               // APB byte address
    input  wire logic [31:0]             pwdata,              // APB write data
    output logic      [31:0]             prdata,              // APB read data
    output logic                         pready,              // APB ready
    output logic                         pslverr,             // APB error
    input  wire logic                    timer_zero_overflow, // Timer-zero wrap pulse
    input  wire logic                    ext_pin,             // External interrupt pin
    input  wire logic                    ext_edge_select,     // One rising, zero falling
    input  wire logic [PIN_CHANGE_W-1:0] pin_change_flag_reg, // Per-pin change flags
    input  wire logic [7:0]              periph_one_event,    // First group event pulses
    input  wire logic [7:0]              periph_two_pending,  // Second group flags
    input  wire logic                    core_accept,         // Core takes the interrupt
    input  wire logic                    core_return,         // Return from interrupt
    output logic                         core_irq_req,        // Request to the core
    output logic                         sys_irq              // Event interrupt, level
);

    // Control bits of interrupt_control
    logic global_irq_gate_q;                    // Global gate
    logic peripheral_group_gate_q;              // Peripheral group gate
    logic timer_zero_overflow_en_q;             // Timer-zero enable
    logic ext_pin_irq_en_q;                     // External pin enable
    logic pin_change_irq_en_q;                  // Pin-change enable
    logic pin_change_summary_pending_q;         // Pin-change summary flag

    // Peripheral enables and flags
    logic [7:0] peripheral_enable_one_q;        // First enable register
    logic [7:0] peripheral_enable_two_q;        // Second enable register
    logic [7:0] peripheral_request_one_q;       // First request register
    logic [1:0] core_flags_q;                   // Timer-zero and external flags

    // Event status and mask
    logic [ief_pkg::EVT_W-1:0] evt_status_q;    // Sticky event bits
    logic [ief_pkg::EVT_W-1:0] evt_status_d;    // Next event bits
    logic [ief_pkg::EVT_W-1:0] evt_mask_q;      // Event mask
    logic [ief_pkg::EVT_W-1:0] evt_set;         // Events this cycle

    // Bus phase and answer registers
    ief_pkg::ief_phase_t phase_q;               // Access phase tracker
    ief_pkg::ief_phase_t phase_d;               // Next phase
    ief_pkg::ief_rsp_t   rsp_q;                 // Registered answer
    ief_pkg::ief_rsp_t   rsp_d;                 // Answer computed now
    logic                irq_req_q;             // Registered core request
    logic                sys_irq_q;             // Registered event interrupt

    // Decode wires
    wire       access      = psel & penable;
    wire       commit      = access & (phase_q == ief_pkg::IEF_ACK);
    wire       wr_commit   = commit & pwrite;
    wire       rd_commit   = commit & ~pwrite;
    wire       sel_interrupt_control  = (paddr == ief_pkg::OFS_INTERRUPT_CONTROL);
    wire       sel_en_one  = (paddr == ief_pkg::OFS_PERIPHERAL_ENABLE_ONE);
    wire       sel_en_two  = (paddr == ief_pkg::OFS_PERIPHERAL_ENABLE_TWO);
    wire       sel_req_one = (paddr == ief_pkg::OFS_PERIPHERAL_REQUEST_ONE);
    wire       sel_status  = (paddr == ief_pkg::OFS_EVENT_STATUS);
    wire       sel_mask    = (paddr == ief_pkg::OFS_EVENT_MASK);
    wire       mapped      = sel_interrupt_control | sel_en_one | sel_en_two |
                             sel_req_one | sel_status | sel_mask;
    wire       wr_interrupt_control   = wr_commit & sel_interrupt_control;
    wire       wr_req_one  = wr_commit & sel_req_one;
    wire [7:0] wdata       = pwdata[7:0];
    logic      ext_edge;                        // Chosen edge on the pin

    // Edge of the external pin, direction picked by the select input
    ief_edge_detect u_edge (
        .mclk       (mclk),
        .resetn     (resetn),
        .pin        (ext_pin),
        .rise_sel   (ext_edge_select),
        .edge_pulse (ext_edge)
    );

    // Timer-zero and external flags; events set them whatever the enables
    ief_flag_reg #(
        .W    (2),
        .IMPL (ief_pkg::MASK_CORE_FLAGS)
    ) u_core_flags (
        .mclk    (mclk),
        .resetn  (resetn),
        .set     ({timer_zero_overflow, ext_edge}),
        .wr_en   (wr_interrupt_control),
        .wr_data (wdata[ief_pkg::BIT_TIMER_ZERO_PENDING:ief_pkg::BIT_EXT_PIN_PENDING]),
        .flag_q  (core_flags_q)
    );

    // First request register, same layout as the first enable register
    ief_flag_reg #(
        .W    (8),
        .IMPL (ief_pkg::MASK_REQUEST_ONE)
    ) u_req_one (
        .mclk    (mclk),
        .resetn  (resetn),
        .set     (periph_one_event),
        .wr_en   (wr_req_one),
        .wr_data (wdata),
        .flag_q  (peripheral_request_one_q)
    );

    // Named views of the two core flags
    wire timer_zero_overflow_pending = core_flags_q[1];
    wire ext_pin_irq_pending         = core_flags_q[0];

    // Readback of interrupt_control
    wire [7:0] interrupt_control_rd = {global_irq_gate_q, peripheral_group_gate_q,
                            timer_zero_overflow_en_q, ext_pin_irq_en_q,
                            pin_change_irq_en_q, timer_zero_overflow_pending,
                            ext_pin_irq_pending, pin_change_summary_pending_q};

    // Second group flags come from outside; only implemented ones count
    wire [7:0] periph_two_live = periph_two_pending & ief_pkg::MASK_ENABLE_TWO;

    // Sources with both enable and flag set
    wire core_hit = (timer_zero_overflow_en_q & timer_zero_overflow_pending) |
                    (ext_pin_irq_en_q & ext_pin_irq_pending) |
                    (pin_change_irq_en_q & pin_change_summary_pending_q);
    wire periph_hit = (|(peripheral_enable_one_q & peripheral_request_one_q)) |
                      (|(peripheral_enable_two_q & periph_two_live));

    // Request to the core
    wire irq_req_d = global_irq_gate_q &
                     (core_hit | (peripheral_group_gate_q & periph_hit));

    // Read data selection; unimplemented bits masked to zero
    wire [7:0] rd_byte =
        sel_interrupt_control  ? interrupt_control_rd :
        sel_en_one  ? (peripheral_enable_one_q & ief_pkg::MASK_ENABLE_ONE) :
        sel_en_two  ? (peripheral_enable_two_q & ief_pkg::MASK_ENABLE_TWO) :
        sel_req_one ? (peripheral_request_one_q & ief_pkg::MASK_REQUEST_ONE) :
        sel_status  ? {5'h00, evt_status_q} :
        sel_mask    ? {5'h00, evt_mask_q} : 8'h00;

    // Answer prepared in the first access cycle
    assign rsp_d = '{data: {24'h000000, rd_byte}, err: ~mapped};

    // Phase: one wait cycle, then ready
    assign phase_d = (access & (phase_q == ief_pkg::IEF_WAIT)) ?
                     ief_pkg::IEF_ACK : ief_pkg::IEF_WAIT;

    // Events for the status register; reading it clears, events win
    assign evt_set = {ext_edge,
                      core_return,
                      core_accept & global_irq_gate_q};
    // Only the bits handed out in the answer clear, so an event in the wait cycle survives
    wire [ief_pkg::EVT_W-1:0] evt_seen = rsp_q.data[ief_pkg::EVT_W-1:0];
    assign evt_status_d = ((rd_commit & sel_status) ? (evt_status_q & ~evt_seen) : evt_status_q)
                          | evt_set;

    // Bus phase and registered answer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= ief_pkg::IEF_WAIT;
            rsp_q   <= '0;
        end else begin
            phase_q <= phase_d;
            rsp_q   <= rsp_d;
        end
    end

    // Global gate: software write, then core accept and return override
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            global_irq_gate_q <= 1'b0;
        end else if (core_accept && global_irq_gate_q) begin
            global_irq_gate_q <= 1'b0;
        end else if (core_return) begin
            global_irq_gate_q <= 1'b1;
        end else if (wr_interrupt_control) begin
            global_irq_gate_q <= wdata[ief_pkg::BIT_GLOBAL_IRQ_GATE];
        end
    end

    // Writable enables of interrupt_control
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            peripheral_group_gate_q  <= 1'b0;
            timer_zero_overflow_en_q <= 1'b0;
            ext_pin_irq_en_q         <= 1'b0;
            pin_change_irq_en_q      <= 1'b0;
        end else if (wr_interrupt_control) begin
            peripheral_group_gate_q  <= wdata[ief_pkg::BIT_PERIPHERAL_GROUP];
            timer_zero_overflow_en_q <= wdata[ief_pkg::BIT_TIMER_ZERO_EN];
            ext_pin_irq_en_q         <= wdata[ief_pkg::BIT_EXT_PIN_EN];
            pin_change_irq_en_q      <= wdata[ief_pkg::BIT_PIN_CHANGE_EN];
        end
    end

    // Summary flag follows the per-pin flags; bus writes never touch it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_change_summary_pending_q <= 1'b0;
        end else begin
            pin_change_summary_pending_q <= |pin_change_flag_reg;
        end
    end

    // Peripheral enable registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            peripheral_enable_one_q <= ief_pkg::RST_BANK;
            peripheral_enable_two_q <= ief_pkg::RST_BANK;
        end else if (wr_commit) begin
            if (sel_en_one) begin
                peripheral_enable_one_q <= wdata & ief_pkg::MASK_ENABLE_ONE;
            end
            if (sel_en_two) begin
                peripheral_enable_two_q <= wdata & ief_pkg::MASK_ENABLE_TWO;
            end
        end
    end

    // Event status and mask
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            evt_status_q <= ief_pkg::RST_EVT;
            evt_mask_q   <= ief_pkg::RST_EVT;
        end else begin
            evt_status_q <= evt_status_d;
            if (wr_commit && sel_mask) begin
                evt_mask_q <= wdata[ief_pkg::EVT_W-1:0];
            end
        end
    end

    // Registered interrupt outputs
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_req_q <= 1'b0;
            sys_irq_q <= 1'b0;
        end else begin
            irq_req_q <= irq_req_d;
            sys_irq_q <= |(evt_status_d & evt_mask_q);
        end
    end

    // Outputs straight from flip-flops
    assign prdata       = rsp_q.data;
    assign pslverr      = rsp_q.err;
    assign pready       = phase_q[1];
    assign core_irq_req = irq_req_q;
    assign sys_irq      = sys_irq_q;

endmodule : ief_bank

//--- verif/ief_bank_chk.sv
// Checker of bus timing and request behaviour at the interrupt bank ports
`timescale 1ns/1ps
module ief_bank_chk (
    input wire logic        mclk,         // System clock
    input wire logic        resetn,       // Async reset, active low
    input wire logic        psel,         // Bus select
    input wire logic        penable,      // Bus enable
    input wire logic [11:0] paddr,        // Bus byte address
    input wire logic [31:0] prdata,       // Read data
    input wire logic        pready,       // Ready
    input wire logic        pslverr,      // Error
    input wire logic        core_accept,  // Core takes the interrupt
    input wire logic        core_return,  // Return from interrupt
    input wire logic        core_irq_req, // Request to the core
    input wire logic        sys_irq       // Event interrupt
);
    // All checks run on the system clock and rest during reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // Setup cycle, then exactly one wait state before the answer
    sequence s_setup; psel && !penable; endsequence
    sequence s_answer; !pready ##1 pready; endsequence
    // Accept of a live request with no return in the following cycle
    sequence s_accept; (core_accept && core_irq_req && !core_return) ##1 !core_return; endsequence
    property p_ready_wait; s_setup |=> s_answer; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("answer not after one wait");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    property p_idle; !psel |=> !pready ##1 !pready; endproperty
    a_idle: assert property (p_idle) else $error("ready without a transfer");
    property p_err_unmapped; pready && (paddr > 12'h014) |-> pslverr && (prdata == 32'h0); endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    property p_err_mapped; pready && (paddr <= 12'h014) && (paddr[1:0] == 2'h0) |-> !pslverr; endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
    property p_upper_zero; pready |-> (prdata[31:8] == 24'h0); endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("read data high bits set");
    property p_reset_quiet; $rose(resetn) |-> !core_irq_req && !sys_irq && !pready; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_accept_drop; s_accept |=> !core_irq_req; endproperty
    a_accept_drop: assert property (p_accept_drop) else $error("request kept after accept");
endmodule : ief_bank_chk

//--- verif/ief_src_model.sv
// Model of the core and peripheral event sources facing the bank
`timescale 1ns/1ps
module ief_src_model (
    input  wire logic mclk,                // System clock
    output logic      timer_zero_overflow, // Timer-zero wrap pulse
    output logic      ext_pin,             // External pin level
    output logic [7:0] periph_one_event,   // First group event pulses
    output logic      core_accept,         // Core takes the interrupt
    output logic      core_return          // Return from interrupt
);
    // Quiet lines from time zero
    initial begin
        timer_zero_overflow = 1'b0;
        ext_pin             = 1'b0;
        periph_one_event    = 8'h00;
        core_accept         = 1'b0;
        core_return         = 1'b0;
    end
    // One-cycle pulses on the chosen lines, launched after a clock edge
    task automatic pulse(input logic t0, input logic [7:0] p1, input logic acc, input logic ret);
        @(posedge mclk);
        timer_zero_overflow <= t0;
        periph_one_event    <= p1;
        core_accept         <= acc;
        core_return         <= ret;
        @(posedge mclk);
        timer_zero_overflow <= 1'b0;
        periph_one_event    <= 8'h00;
        core_accept         <= 1'b0;
        core_return         <= 1'b0;
    endtask : pulse
    // New pin level, held long enough for the edge to land
    task automatic pin(input logic lvl);
        @(posedge mclk);
        ext_pin <= lvl;
        repeat (3) @(posedge mclk);
    endtask : pin
endmodule : ief_src_model

//--- verif/ief_bank_tb.sv
// Self-checking bench for the interrupt enable and flag bank
`timescale 1ns/1ps
module ief_bank_tb;
    localparam logic [11:0] A_CTL = ief_pkg::OFS_INTERRUPT_CONTROL;      // Control
    localparam logic [11:0] A_PE1 = ief_pkg::OFS_PERIPHERAL_ENABLE_ONE;  // First enables
    localparam logic [11:0] A_PE2 = ief_pkg::OFS_PERIPHERAL_ENABLE_TWO;  // Second enables
    localparam logic [11:0] A_PR1 = ief_pkg::OFS_PERIPHERAL_REQUEST_ONE; // First requests
    localparam logic [11:0] A_EST = ief_pkg::OFS_EVENT_STATUS;           // Event status
    localparam logic [11:0] A_EMK = ief_pkg::OFS_EVENT_MASK;             // Event mask
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, last_err; // Bus
    logic [11:0] paddr;                                    // Byte address
    logic [31:0] pwdata, prdata;                           // Data
    logic        ext_edge_select, core_irq_req, sys_irq;   // Levels
    logic [7:0]  pin_change_flag_reg, periph_two_pending;  // Level flags
    logic        timer_zero_overflow, ext_pin, core_accept, core_return; // From model
    logic [7:0]  periph_one_event;                         // From model
    int          checked, miscompares;                     // Tallies

    ief_bank uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_zero_overflow(timer_zero_overflow), .ext_pin(ext_pin),
        .ext_edge_select(ext_edge_select), .pin_change_flag_reg(pin_change_flag_reg),
        .periph_one_event(periph_one_event), .periph_two_pending(periph_two_pending),
        .core_accept(core_accept), .core_return(core_return),
        .core_irq_req(core_irq_req), .sys_irq(sys_irq));
    ief_src_model src (.mclk(mclk), .timer_zero_overflow(timer_zero_overflow), .ext_pin(ext_pin),
        .periph_one_event(periph_one_event), .core_accept(core_accept), .core_return(core_return));

    // 20 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Compare and tally
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Counts, verdict and end of run
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // One bus transfer: setup, access held until ready, then release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk("pready", {31'h0, pready}, 32'h1);
        if (pready !== 1'b1) report_and_stop();
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk($sformatf("reg_%h", a), q, e);
    endtask : rdchk
    // Bounded wait for a request line to reach a level
    task automatic wait_lvl(input logic s, input logic e);
        int n;
        n = 0;
        while ((s ? sys_irq : core_irq_req) !== e && n < 8) begin
            @(posedge mclk);
            n++;
        end
        chk(s ? "sys_irq" : "core_irq_req", {31'h0, s ? sys_irq : core_irq_req}, {31'h0, e});
        if ((s ? sys_irq : core_irq_req) !== e) report_and_stop();
    endtask : wait_lvl

    task automatic t_reset;
        for (int i = 0; i < 6; i++) rdchk(12'(i * 4), 32'h0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_regs;
        wr(A_PE1, 32'hffff_ffff);
        wr(A_PE2, 32'hffff_ffff);
        rdchk(A_PE1, {24'h0, ief_pkg::MASK_ENABLE_ONE});
        rdchk(A_PE2, {24'h0, ief_pkg::MASK_ENABLE_TWO});
        wr(A_PE1, 32'h0);
        wr(A_PE2, 32'h0);
        wr(A_CTL, 32'h7f);
        rdchk(A_CTL, 32'h7e);
        chk("core_irq_req", {31'h0, core_irq_req}, 32'h0);
        wr(A_CTL, 32'h0);
        rdchk(A_CTL, 32'h0);
        rdchk(12'h018, 32'h0);
        chk("pslverr", {31'h0, last_err}, 32'h1);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_flags;
        src.pulse(1'b1, 8'hff, 1'b0, 1'b0);
        ext_edge_select <= 1'b1;
        src.pin(1'b1);
        rdchk(A_CTL, 32'h6);
        rdchk(A_PR1, {24'h0, ief_pkg::MASK_REQUEST_ONE});
        wr(A_CTL, 32'h0);
        ext_edge_select <= 1'b0;
        src.pin(1'b0);
        rdchk(A_CTL, 32'h2);
        wr(A_CTL, 32'h0);
        src.pin(1'b1);
        rdchk(A_CTL, 32'h0);
        fork
            wr(A_PR1, 32'h0);
            begin
                repeat (2) @(posedge mclk);
                src.pulse(1'b0, 8'h01, 1'b0, 1'b0);
            end
        join
        rdchk(A_PR1, 32'h1);
        wr(A_PR1, 32'h0);
        rdchk(A_PR1, 32'h0);
        $display("t_flags done");
    endtask : t_flags
    task automatic t_irq;
        wr(A_CTL, 32'ha0); // enable only while the flags are clear
        src.pulse(1'b1, 8'h0, 1'b0, 1'b0);
        wait_lvl(1'b0, 1'b1);
        src.pulse(1'b0, 8'h0, 1'b1, 1'b0);
        wait_lvl(1'b0, 1'b0);
        rdchk(A_CTL, 32'h24);
        src.pulse(1'b0, 8'h0, 1'b0, 1'b1);
        wait_lvl(1'b0, 1'b1);
        wr(A_CTL, 32'h80);
        wr(A_PE1, 32'h1);
        src.pulse(1'b0, 8'h01, 1'b0, 1'b0);
        rdchk(A_PR1, 32'h1);
        chk("core_irq_req", {31'h0, core_irq_req}, 32'h0);
        wr(A_CTL, 32'hc0);
        wait_lvl(1'b0, 1'b1);
        wr(A_PR1, 32'h0);
        wait_lvl(1'b0, 1'b0);
        periph_two_pending <= 8'h11;
        wr(A_PE2, 32'hff);
        repeat (2) @(posedge mclk);
        chk("core_irq_req", {31'h0, core_irq_req}, 32'h0);
        periph_two_pending <= 8'h02;
        wait_lvl(1'b0, 1'b1);
        periph_two_pending <= 8'h00;
        wr(A_CTL, 32'h0);
        wr(A_PE1, 32'h0);
        wr(A_PE2, 32'h0);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_pinchg;
        pin_change_flag_reg <= 8'h10;
        wr(A_CTL, 32'h0);
        rdchk(A_CTL, 32'h1);
        wr(A_CTL, 32'h88);
        wait_lvl(1'b0, 1'b1);
        pin_change_flag_reg <= 8'h00;
        wait_lvl(1'b0, 1'b0);
        rdchk(A_CTL, 32'h88);
        wr(A_CTL, 32'h0);
        $display("t_pinchg done");
    endtask : t_pinchg
    // Sticky event status, clear on read, mask on the level output
    task automatic t_events;
        rdchk(A_EST, 32'h7);
        rdchk(A_EST, 32'h0);
        wr(A_EMK, 32'h2);
        src.pulse(1'b0, 8'h0, 1'b0, 1'b1);
        wait_lvl(1'b1, 1'b1);
        wr(A_EMK, 32'h0);
        wait_lvl(1'b1, 1'b0);
        wr(A_EMK, 32'h2);
        wait_lvl(1'b1, 1'b1);
        rdchk(A_EST, 32'h2);
        wait_lvl(1'b1, 1'b0);
        rdchk(A_EMK, 32'h2);
        wr(A_CTL, 32'h0);
        $display("t_events done");
    endtask : t_events

    // Reset for two cycles, then the scenarios in turn
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_edge_select = 1'b0;
        pin_change_flag_reg = 8'h00;
        periph_two_pending = 8'h00;
        checked = 0;
        miscompares = 0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_flags();
        t_irq();
        t_pinchg();
        t_events();
        report_and_stop();
    end
endmodule : ief_bank_tb

bind ief_bank ief_bank_chk chk (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_accept(core_accept), .core_return(core_return), .core_irq_req(core_irq_req),
    .sys_irq(sys_irq));
